/* hdl/bts_decode.sv */
`timescale 1ns/10ps
`include "bts_regs.svh"
// Summary of operation
// RULE_01 - Upper nibble 0110 decodes skip-when-clear; bits 7:5 bit, 4:0 file.
// RULE_02 - Skip-when-clear skips the next instruction only when the bit reads zero.
// RULE_03 - A taken clear-skip discards the prefetch and runs a no-op, two cycles.
// RULE_04 - Upper nibble 0111 decodes skip-when-set with the same fields.
// RULE_05 - Skip-when-set skips the next instruction only when the bit reads one.
// RULE_06 - A taken set-skip flushes the prefetch and substitutes a no-op cycle.
// RULE_07 - No flag or register is written; without a skip the PC simply advances.
// RULE_08 - One instruction cycle is four oscillator periods; taken tests take two.
module bts_decode #(
  parameter int PC_W = 9
) (
  // Clock and reset.
  input  wire logic                clock,
  input  wire logic                rstn,
  // Prefetched instruction from program memory.
  input  wire bts_pkg::bts_insn_s  fetch_word,
  // File register read port.
  output      logic [4:0]          file_raddr,
  input  wire logic [7:0]          file_rdata,
  // Core control.
  output      logic [PC_W-1:0]     pc,
  output      logic                insn_cycle,
  output      logic                exec_nop,
  output      logic                skip_taken,
  output      bts_pkg::bts_insn_s  exec_word,
  output      logic                status_we,
  output      logic                file_we
);
  import bts_pkg::*;

  // Refuse program counter widths that the increment and reset logic cannot serve.
  if (PC_W < 1 || PC_W > 16)
  begin : g_pc_w_check
    $error("PC width out of range");
  end

  //--------------------------------------------------------------------
  // Instruction cycle enable
  //--------------------------------------------------------------------
  logic [1:0]  osc_cnt_q;
  bts_state_e  state_q;
  bts_kind_e   kind;
  logic        bit_val;
  logic        do_skip;

  // Divide the clock by four so each execute step is one instruction cycle.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      osc_cnt_q <= 2'h0;
    else
      osc_cnt_q <= osc_cnt_q + 2'h1;                          // RULE_08
  end
  assign insn_cycle = (osc_cnt_q == 2'(`BTS_OSC_PER_CYCLE - 1)); // RULE_08

  //--------------------------------------------------------------------
  // Decode
  //--------------------------------------------------------------------
  // Classify the executing word by its upper nibble. Every other opcode is
  // left to the rest of the core and never starts a skip here.
  function automatic bts_kind_e classify(input bts_insn_s w);
    if (w.opcode == `BTS_OPC_SKIP_CLEAR)
      return BTS_SKIP_CLEAR;                                  // RULE_01
    else if (w.opcode == `BTS_OPC_SKIP_SET)
      return BTS_SKIP_SET;                                    // RULE_04
    else
      return BTS_OTHER;
  endfunction

  // The file address is driven straight from the executing word so the
  // register read settles well inside the four-clock instruction cycle.
  assign file_raddr = exec_word.file_addr;                    // RULE_01
  assign kind       = (state_q == BTS_FLUSH) ? BTS_OTHER : classify(exec_word);
  assign bit_val    = file_rdata[exec_word.bit_sel];

  // Skip decision for the word in execute. A flushed no-op decodes as
  // another class, so it can never start a second skip of its own.
  always_comb
  begin
    case (kind)
      BTS_SKIP_CLEAR: do_skip = ~bit_val;                     // RULE_02
      BTS_SKIP_SET:   do_skip = bit_val;                      // RULE_05
      default:        do_skip = 1'b0;
    endcase
  end

  // Bit tests are read-only: they never request a write anywhere.
  assign status_we = 1'b0;                                    // RULE_07
  assign file_we   = 1'b0;                                    // RULE_07
  assign exec_nop  = (state_q == BTS_FLUSH);

  //--------------------------------------------------------------------
  // Execute pipeline
  //--------------------------------------------------------------------
  // A taken skip replaces the prefetched word with a no-op, costing one
  // extra instruction cycle rather than stalling the fetch unit.
  // Flush marker: set for the instruction cycle that runs the no-op.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      state_q <= BTS_EXEC;
    else if (insn_cycle)
    begin
      if (do_skip)
        state_q <= BTS_FLUSH;                                 // RULE_03 RULE_06
      else
        state_q <= BTS_EXEC;
    end
  end

  // Executing word: the prefetched word, or a no-op in its place after a skip.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      exec_word <= `BTS_NOP_WORD;
    else if (insn_cycle)
    begin
      if (do_skip)
        exec_word <= `BTS_NOP_WORD;                           // RULE_03 RULE_06
      else
        exec_word <= fetch_word;                              // RULE_07
    end
  end

  // Skip result of the instruction that has just finished its cycle.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      skip_taken <= 1'b0;
    else if (insn_cycle)
      skip_taken <= do_skip;                                  // RULE_02 RULE_05
  end

  // Program counter advances once per instruction cycle in either case.
  // There is no stall: the fetch unit must already hold the next word.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      pc <= PC_W'(`BTS_PC_RESET);
    else if (insn_cycle)
      pc <= pc + PC_W'(1);                                    // RULE_07
  end

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // Skip outcomes on the edge that ends the instruction cycle.
  clear_skip_a: assert property (insn_cycle && kind == BTS_SKIP_CLEAR && !bit_val // RULE_02
    |=> state_q == BTS_FLUSH && exec_word == `BTS_NOP_WORD)
    else $error("clear skip not taken");
  clear_noskip_a: assert property (insn_cycle && kind == BTS_SKIP_CLEAR && bit_val // RULE_02
    |=> state_q == BTS_EXEC)
    else $error("clear skip taken wrongly");
  set_skip_a: assert property (insn_cycle && kind == BTS_SKIP_SET && bit_val // RULE_05
    |=> exec_nop)
    else $error("set skip not taken");
  set_noskip_a: assert property (insn_cycle && kind == BTS_SKIP_SET && !bit_val // RULE_05
    |=> !exec_nop)
    else $error("set skip taken wrongly");
  flush_len_a: assert property ($rose(exec_nop) |-> exec_nop [*4] ##1 !exec_nop) // RULE_06
    else $error("flush not one cycle");
  decode_a: assert property (kind != BTS_OTHER |-> exec_word.opcode[3:1] == 3'h3) // RULE_04
    else $error("bad decode");
  no_write_a: assert property (!status_we && !file_we) // RULE_07
    else $error("bit test wrote state");
  pc_step_a: assert property (insn_cycle |=> pc == $past(pc) + PC_W'(1)) // RULE_07
    else $error("pc did not advance");
  cyc_len_a: assert property (insn_cycle |=> !insn_cycle [*3] ##1 insn_cycle) // RULE_08
    else $error("cycle not four clocks");

  // Field positions checked against the raw word rather than the struct.
  addr_pick_a: assert property (file_raddr == exec_word[`BTS_FILE_HI:`BTS_FILE_LO]) // RULE_01
    else $error("file address field misplaced");
  bit_pick_a: assert property ( // RULE_01
    bit_val == file_rdata[exec_word[`BTS_BIT_HI:`BTS_BIT_LO]])
    else $error("bit position field misplaced");

  // Both opcodes decode outside a flush, using the raw upper nibble.
  clear_map_a: assert property ( // RULE_01
    !exec_nop && exec_word[`BTS_OPC_HI:`BTS_OPC_LO] == `BTS_OPC_SKIP_CLEAR
    |-> kind == BTS_SKIP_CLEAR)
    else $error("clear opcode not decoded");
  set_map_a: assert property ( // RULE_04
    !exec_nop && exec_word[`BTS_OPC_HI:`BTS_OPC_LO] == `BTS_OPC_SKIP_SET
    |-> kind == BTS_SKIP_SET)
    else $error("set opcode not decoded");

  // A word that is not skipped is executed exactly as it was prefetched.
  load_word_a: assert property (insn_cycle && !do_skip // RULE_07
    |=> exec_word == $past(fetch_word))
    else $error("prefetched word not loaded");

  // The substituted no-op lasts one instruction cycle and cannot skip.
  nop_once_a: assert property (insn_cycle && exec_nop |=> !exec_nop && !skip_taken) // RULE_03
    else $error("no-op cycle misbehaved");

  // A taken skip costs two instruction cycles: the program counter has
  // stepped twice by the time the next real word starts.
  two_cycle_a: assert property (insn_cycle && do_skip // RULE_08
    |-> ##5 pc == $past(pc, 5) + PC_W'(2))
    else $error("taken skip not two cycles");

  // Outputs stand for the whole instruction cycle between enable pulses.
  output_hold_a: assert property (!insn_cycle // RULE_08
    |=> $stable(exec_word) && $stable(pc) && $stable(skip_taken) && $stable(exec_nop))
    else $error("output changed inside a cycle");

  //--------------------------------------------------------------------
  // Coverage
  //--------------------------------------------------------------------
  cov_clear_c: cover property (insn_cycle && kind == BTS_SKIP_CLEAR && do_skip);
  cov_set_c:   cover property (insn_cycle && kind == BTS_SKIP_SET && do_skip);
  cov_none_c:  cover property (insn_cycle && kind != BTS_OTHER && !do_skip);
  cov_set_none_c:  cover property (insn_cycle && kind == BTS_SKIP_SET && !do_skip);
  cov_after_nop_c: cover property (insn_cycle && exec_nop ##4 insn_cycle && kind != BTS_OTHER);

endmodule

/* hdl/bts_regs.svh */
`ifndef BTS_REGS_SVH
`define BTS_REGS_SVH

//----------------------------------------------------------------------
// Instruction encoding
//----------------------------------------------------------------------
`define BTS_OPC_HI         11
`define BTS_OPC_LO         8
`define BTS_OPC_SKIP_CLEAR 4'h6
`define BTS_OPC_SKIP_SET   4'h7
`define BTS_BIT_HI         7
`define BTS_BIT_LO         5
`define BTS_FILE_HI        4
`define BTS_FILE_LO        0
`define BTS_NOP_WORD       12'h000

//----------------------------------------------------------------------
// Timing
//----------------------------------------------------------------------
`define BTS_OSC_PER_CYCLE  4
`define BTS_PC_RESET       9'h000

`endif

/* hdl/bts_pkg.sv */
package bts_pkg;

  // Instruction word as laid out for bit-oriented operations.
  typedef struct packed
  {
    logic [3:0] opcode;
    logic [2:0] bit_sel;
    logic [4:0] file_addr;
  } bts_insn_s;

  // Instruction classes this block recognises.
  typedef enum logic [1:0]
  {
    BTS_OTHER,
    BTS_SKIP_CLEAR,
    BTS_SKIP_SET
  } bts_kind_e;

  // Per-cycle execute outcome.
  typedef enum logic [1:0]
  {
    BTS_EXEC,
    BTS_FLUSH
  } bts_state_e;

endpackage

/* tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import bts_pkg::*;
  //--------------------------------------------------------------------
  // Stimulus and expectations
  //--------------------------------------------------------------------
  typedef struct packed
  {
    bts_insn_s  w;
    logic       n;
    logic       s;
    logic [8:0] p;
  } bts_exp_s;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  bts_insn_s   fetch_word = 12'h000;
  logic [7:0]  file_rdata = 8'h00;
  logic [4:0]  file_raddr;
  logic [8:0]  pc;
  logic        insn_cycle, exec_nop, skip_taken, status_we, file_we;
  bts_insn_s   exec_word;
  bts_exp_s    q[$];
  bts_exp_s    e, m;
  logic        sk;
  logic [31:0] seed = 32'h0001_5b61;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          gap = 0;

  bts_decode #(.PC_W(9)) u_bts_decode (.clock(clock), .rstn(rstn),
    .fetch_word(fetch_word), .file_raddr(file_raddr), .file_rdata(file_rdata),
    .pc(pc), .insn_cycle(insn_cycle), .exec_nop(exec_nop), .skip_taken(skip_taken),
    .exec_word(exec_word), .status_we(status_we), .file_we(file_we));

  // Free-running 25 MHz clock.
  always #20 clock = ~clock;

  // One xorshift step; every random value of the bench comes from it.
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // Compare one observed value with its expectation.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Print the verdict once and end the run.
  task end_of_test;
    if (n_mismatch == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Random words lean towards the two skip opcodes so both paths run often.
  // Between instruction cycles the inputs carry noise that must be ignored.
  initial
  begin
    repeat (4) @(posedge clock);
    #1 rstn = 1'b1;
    e = '0;
    repeat (800)
    begin
      @(posedge clock);
      #1;
      seed = xorshift(seed);
      if (insn_cycle === 1'b1)
      begin
        fetch_word = (seed[3:2] != 2'h0) ? {3'h3, seed[0], seed[11:4]} : seed[27:16];
        file_rdata = seed[31:24];
        check(16'(file_raddr), 16'(e.w.file_addr));
        sk = (e.w.opcode == 4'h6 && !file_rdata[e.w.bit_sel]) ||
             (e.w.opcode == 4'h7 && file_rdata[e.w.bit_sel]);
        e = sk ? {12'h000, 2'h3, e.p + 9'h001} : {fetch_word, 2'h0, e.p + 9'h001};
        q.push_back(e);
      end
      else
      begin
        fetch_word = seed[11:0];
        file_rdata = seed[23:16];
      end
    end
    // Let the checker take the last note before the verdict.
    wait (q.size() == 0);
    #5;
    end_of_test;
  end

  // The note pushed in an instruction cycle is checked after that cycle's edge.
  initial forever
  begin
    @(posedge clock);
    gap++;
    if (q.size() > 0)
    begin
      #2;
      m = q.pop_front();
      check(16'(skip_taken), 16'(m.s));
      check(16'(exec_nop), 16'(m.n));
      check(16'(exec_word), 16'(m.w));
      check(16'(pc), 16'(m.p));
      check(16'({status_we, file_we}), 16'h0000);
      if (m.p != 9'h001) check(16'(gap), 16'h0004);
      gap = 0;
    end
  end

  // Hang guard, sized well beyond the 800-cycle run.
  initial
  begin
    #50000;
    n_mismatch++;
    end_of_test;
  end
endmodule
